// ===== alm_pkg.sv
// Types shared by the alarm status bank
package alm_pkg;
   typedef logic [15:0] alm_word_t;
   typedef logic [6:0]  alm_lane_t;
   typedef logic [7:0]  alm_addr_t;
endpackage

// ===== alm_regs.svh
// Register offsets, field positions, reset values and timing counts of the alarm status bank
`ifndef ALM_REGS_SVH
`define ALM_REGS_SVH

// Register offsets on the plain access port
`define ALM_OFS_FAIL      8'h04
`define ALM_OFS_STAT      8'h05
`define ALM_OFS_ENA       8'h0A

// Status word field positions
`define ALM_B_ZERO_A      15
`define ALM_B_ZERO_B      14
`define ALM_F_FIFO_A_HI   13
`define ALM_F_FIFO_A_LO   11
`define ALM_F_FIFO_B_HI   10
`define ALM_F_FIFO_B_LO   8
`define ALM_B_SCLK_LOST   7
`define ALM_B_DCLK_LOST   6
`define ALM_B_CLK_GONE    5
`define ALM_B_MISM_A      4
`define ALM_B_MISM_B      3

// Enable register field positions
`define ALM_B_ENA_TWO     3
`define ALM_B_ENA_ONE     2
`define ALM_B_ENA_COLL    1

// Reset values and the midscale override code
`define ALM_RST_FAIL      14'h0000
`define ALM_RST_STAT      13'h0000
`define ALM_RST_ENA       3'h7
`define ALM_MIDSCALE      16'h8000

// Clock loss threshold, doubled per interpolation step
`define ALM_LOSS_BASE     16'h0010

`endif

// ===== alm_status.sv
// Alarm and input-check status registers with midscale override of the serializer
`timescale 1ns/100ps
`include "alm_regs.svh"

module alm_status
   import alm_pkg::*;
(
   input  wire logic      ref_clk,
   input  wire logic      rst,
   input  wire alm_addr_t reg_addr,
   input  wire alm_word_t reg_wdata,
   input  wire logic      reg_wr,
   input  wire logic      reg_rd,
   output alm_word_t      reg_rdata,
   input  wire logic [7:0] wr_ptr_a,
   input  wire logic [7:0] wr_ptr_b,
   input  wire logic      fifo_a_two_apart,
   input  wire logic      fifo_a_one_apart,
   input  wire logic      fifo_a_collision,
   input  wire logic      fifo_b_two_apart,
   input  wire logic      fifo_b_one_apart,
   input  wire logic      fifo_b_collision,
   input  wire logic      sample_clk_tick,
   input  wire logic      data_clk_tick,
   input  wire logic [1:0] interp_sel,
   input  wire logic      check_valid,
   input  wire alm_lane_t rx_lane_a,
   input  wire alm_lane_t rx_lane_b,
   input  wire alm_lane_t exp_lane_a,
   input  wire alm_lane_t exp_lane_b,
   input  wire alm_word_t sample_a,
   input  wire alm_word_t sample_b,
   output alm_word_t      output_serializer_a,
   output alm_word_t      output_serializer_b
);

   // Stored state
   logic [13:0] fail_r;
   logic [13:0] fail_nxt;
   logic [12:0] stat_r;
   logic [12:0] stat_nxt;
   logic [2:0]  ena_r;
   logic [2:0]  ena_nxt;
   alm_word_t   rdata_r;
   alm_word_t   ser_a_r;
   alm_word_t   ser_b_r;
   logic [15:0] sclk_cnt_r;
   logic [15:0] dclk_cnt_r;

   // Address decode
   wire logic wr_fail = reg_wr && (reg_addr == `ALM_OFS_FAIL);
   wire logic wr_stat = reg_wr && (reg_addr == `ALM_OFS_STAT);
   wire logic wr_ena  = reg_wr && (reg_addr == `ALM_OFS_ENA);

   // Full status word view; low three bits are reserved zero
   wire alm_word_t stat_word = {stat_r, 3'h0};
   wire alm_word_t fail_word = {2'h0, fail_r};
   wire alm_word_t ena_word  = {12'h000, ena_r, 1'b0};

   // Read data selection, unmapped offsets read zero
   wire alm_word_t rd_mux =
      (reg_addr == `ALM_OFS_FAIL) ? fail_word :
      (reg_addr == `ALM_OFS_STAT) ? stat_word :
      (reg_addr == `ALM_OFS_ENA)  ? ena_word  : 16'h0000;

   // Self-check compare; ports A and B land on upper and lower lanes
   wire alm_lane_t diff_a = check_valid ? (rx_lane_a ^ exp_lane_a) : 7'h00;
   wire alm_lane_t diff_b = check_valid ? (rx_lane_b ^ exp_lane_b) : 7'h00;
   wire logic [13:0] fail_set = {diff_a, diff_b};
   wire logic mism_a = |diff_a;
   wire logic mism_b = |diff_b;

   // A zero pointer never shifts again; only a sync from outside recovers it
   wire logic zero_a = (wr_ptr_a == 8'h00);
   wire logic zero_b = (wr_ptr_b == 8'h00);

   // Pointer proximity events gated by their enables
   wire logic [2:0] fifo_a_set = {fifo_a_collision & ena_r[0],
                                  fifo_a_one_apart & ena_r[1],
                                  fifo_a_two_apart & ena_r[2]};
   wire logic [2:0] fifo_b_set = {fifo_b_collision & ena_r[0],
                                  fifo_b_one_apart & ena_r[1],
                                  fifo_b_two_apart & ena_r[2]};

   // Loss limit scales with interpolation since clocks slow down with it
   wire logic [15:0] loss_limit = `ALM_LOSS_BASE << interp_sel;
   wire logic sclk_lost = (sclk_cnt_r >= loss_limit);
   wire logic dclk_lost = (dclk_cnt_r >= loss_limit);
   wire logic any_lost  = sclk_lost | dclk_lost;

   // Set vector aligned to stat_r bits 12:0 (status word 15:3)
   wire logic [12:0] stat_set = {zero_a, zero_b, fifo_a_set, fifo_b_set,
                                 sclk_lost, dclk_lost, any_lost, mism_a, mism_b};

   // Write keeps bits written one and clears bits written zero; set beats clear
   wire logic [12:0] stat_keep = wr_stat ? reg_wdata[15:3] : 13'h1FFF;
   wire logic [13:0] fail_keep = wr_fail ? reg_wdata[13:0] : 14'h3FFF;

   // Next-state terms for the sticky registers
   always_comb begin
      stat_nxt = (stat_r & stat_keep) | stat_set;
      fail_nxt = (fail_r & fail_keep) | fail_set;
      ena_nxt  = wr_ena ? reg_wdata[`ALM_B_ENA_TWO:`ALM_B_ENA_COLL] : ena_r;
   end

   // Register bank
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fail_r <= `ALM_RST_FAIL;
         stat_r <= `ALM_RST_STAT;
         ena_r  <= `ALM_RST_ENA;
      end else begin
         fail_r <= fail_nxt;
         stat_r <= stat_nxt;
         ena_r  <= ena_nxt;
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_r <= 16'h0000;
      end else begin
         rdata_r <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   // Stop counters; saturate so a dead clock keeps the alarm asserting
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sclk_cnt_r <= 16'h0000;
         dclk_cnt_r <= 16'h0000;
      end else begin
         if (sample_clk_tick) begin
            sclk_cnt_r <= 16'h0000;
         end else if (sclk_cnt_r != 16'hFFFF) begin
            sclk_cnt_r <= sclk_cnt_r + 16'h0001;
         end
         if (data_clk_tick) begin
            dclk_cnt_r <= 16'h0000;
         end else if (dclk_cnt_r != 16'hFFFF) begin
            dclk_cnt_r <= dclk_cnt_r + 16'h0001;
         end
      end
   end

   // Serializer override holds midscale until software clears the bit
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ser_a_r <= 16'h0000;
         ser_b_r <= 16'h0000;
      end else begin
         ser_a_r <= stat_r[`ALM_B_CLK_GONE - 3] ? `ALM_MIDSCALE : sample_a;
         ser_b_r <= stat_r[`ALM_B_CLK_GONE - 3] ? `ALM_MIDSCALE : sample_b;
      end
   end

   assign reg_rdata           = rdata_r;
   assign output_serializer_a = ser_a_r;
   assign output_serializer_b = ser_b_r;

   // Failure bit of port A lane lands in upper half
   property p_fail_lane;
      @(posedge ref_clk) disable iff (rst)
      (check_valid && (rx_lane_a[0] != exp_lane_a[0])) |=> fail_r[7];
   endproperty
   a_fail_lane: assert property (p_fail_lane) else $error("port A lane 0 failure lost");

   // Port B mismatch alarm
   property p_mism_b;
      @(posedge ref_clk) disable iff (rst)
      (check_valid && (rx_lane_b != exp_lane_b)) |=> stat_word[`ALM_B_MISM_B];
   endproperty
   a_mism_b: assert property (p_mism_b) else $error("port B mismatch not flagged");

   // Zero pointer on channel A
   property p_zero_a;
      @(posedge ref_clk) disable iff (rst)
      (wr_ptr_a == 8'h00) |=> stat_word[`ALM_B_ZERO_A];
   endproperty
   a_zero_a: assert property (p_zero_a) else $error("channel A zero pointer missed");

   // Zero pointer on channel B
   property p_zero_b;
      @(posedge ref_clk) disable iff (rst)
      (wr_ptr_b == 8'h00) |=> stat_word[`ALM_B_ZERO_B];
   endproperty
   a_zero_b: assert property (p_zero_b) else $error("channel B zero pointer missed");

   // Disabled collision alarm never sets the field on its own
   property p_coll_gate;
      @(posedge ref_clk) disable iff (rst)
      (!ena_r[0] && !stat_word[`ALM_F_FIFO_A_HI]) ##1 !ena_r[0] |-> !stat_word[`ALM_F_FIFO_A_HI];
   endproperty
   a_coll_gate: assert property (p_coll_gate) else $error("collision set while disabled");

   // Channel B two-apart code
   property p_two_b;
      @(posedge ref_clk) disable iff (rst)
      (fifo_b_two_apart && ena_r[2]) |=> stat_word[`ALM_F_FIFO_B_LO];
   endproperty
   a_two_b: assert property (p_two_b) else $error("channel B two-apart missed");

   // Clock gone accompanies either loss alarm
   property p_gone;
      @(posedge ref_clk) disable iff (rst)
      ($rose(stat_word[`ALM_B_SCLK_LOST]) || $rose(stat_word[`ALM_B_DCLK_LOST]))
         |-> stat_word[`ALM_B_CLK_GONE];
   endproperty
   a_gone: assert property (p_gone) else $error("clock gone not set with loss");

   // Sample clock loss after the base count at no interpolation
   property p_sclk_loss;
      @(posedge ref_clk) disable iff (rst)
      (interp_sel == 2'h0 && sclk_cnt_r == 16'h0010) |=> stat_word[`ALM_B_SCLK_LOST];
   endproperty
   a_sclk_loss: assert property (p_sclk_loss) else $error("sample clock loss late");

   // Midscale output while clock gone
   property p_mid;
      @(posedge ref_clk) disable iff (rst)
      stat_word[`ALM_B_CLK_GONE] |=> (output_serializer_a == 16'h8000 &&
                                      output_serializer_b == 16'h8000);
   endproperty
   a_mid: assert property (p_mid) else $error("serializer not at midscale");

   // Sticky without a write to the status word
   property p_sticky;
      @(posedge ref_clk) disable iff (rst)
      (stat_word[`ALM_B_ZERO_A] && !wr_stat) |=> stat_word[`ALM_B_ZERO_A];
   endproperty
   a_sticky: assert property (p_sticky) else $error("sticky alarm dropped");

   // Reserved bits read zero
   property p_rsvd;
      @(posedge ref_clk) disable iff (rst)
      (reg_rd && reg_addr == `ALM_OFS_FAIL) |=> (reg_rdata[15:14] == 2'h0);
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

   // Port B top lane lands just below the port A half
   property p_fail_lane_b;
      @(posedge ref_clk) disable iff (rst)
      (check_valid && (rx_lane_b[6] != exp_lane_b[6])) |=> fail_r[6];
   endproperty
   a_fail_lane_b: assert property (p_fail_lane_b) else $error("port B lane 6 lost");

   // Port A top lane is the top failure bit
   property p_fail_top;
      @(posedge ref_clk) disable iff (rst)
      (check_valid && (rx_lane_a[6] != exp_lane_a[6])) |=> fail_r[13];
   endproperty
   a_fail_top: assert property (p_fail_top) else $error("port A lane 6 lost");

   // Port A mismatch alarm
   property p_mism_a;
      @(posedge ref_clk) disable iff (rst)
      (check_valid && (rx_lane_a != exp_lane_a)) |=> stat_word[`ALM_B_MISM_A];
   endproperty
   a_mism_a: assert property (p_mism_a) else $error("port A mismatch not flagged");

   // No self-check running, so no new port A mismatch
   property p_mism_quiet;
      @(posedge ref_clk) disable iff (rst)
      (!check_valid && !stat_word[`ALM_B_MISM_A]) |=> !stat_word[`ALM_B_MISM_A];
   endproperty
   a_mism_quiet: assert property (p_mism_quiet) else $error("mismatch without check");

   // Channel A collision lands in the top field bit
   property p_coll_a;
      @(posedge ref_clk) disable iff (rst)
      (fifo_a_collision && ena_r[0]) |=> stat_word[`ALM_F_FIFO_A_HI];
   endproperty
   a_coll_a: assert property (p_coll_a) else $error("channel A collision missed");

   // Channel A one-apart code
   property p_one_a;
      @(posedge ref_clk) disable iff (rst)
      (fifo_a_one_apart && ena_r[1]) |=> stat_word[`ALM_F_FIFO_A_HI - 1];
   endproperty
   a_one_a: assert property (p_one_a) else $error("channel A one-apart missed");

   // Channel B collision
   property p_coll_b;
      @(posedge ref_clk) disable iff (rst)
      (fifo_b_collision && ena_r[0]) |=> stat_word[`ALM_F_FIFO_B_HI];
   endproperty
   a_coll_b: assert property (p_coll_b) else $error("channel B collision missed");

   // Disabled one-apart alarm never sets its bit
   property p_one_gate;
      @(posedge ref_clk) disable iff (rst)
      (!ena_r[1] && !stat_word[`ALM_F_FIFO_A_HI - 1]) |=> !stat_word[`ALM_F_FIFO_A_HI - 1];
   endproperty
   a_one_gate: assert property (p_one_gate) else $error("one-apart set while disabled");

   // Data clock loss at the largest interpolation setting
   property p_dclk_loss;
      @(posedge ref_clk) disable iff (rst)
      (interp_sel == 2'h3 && dclk_cnt_r == 16'h0080) |=> stat_word[`ALM_B_DCLK_LOST];
   endproperty
   a_dclk_loss: assert property (p_dclk_loss) else $error("data clock loss late");

   // Sample clock loss never flagged before its count at interpolation two
   property p_sclk_early;
      @(posedge ref_clk) disable iff (rst)
      (interp_sel == 2'h2 && sclk_cnt_r < 16'h0040 && !stat_word[`ALM_B_SCLK_LOST])
         |=> !stat_word[`ALM_B_SCLK_LOST];
   endproperty
   a_sclk_early: assert property (p_sclk_early) else $error("sample clock loss early");

   // Writing zero to clock gone clears it once both clocks run again
   property p_clear_gone;
      @(posedge ref_clk) disable iff (rst)
      (wr_stat && !reg_wdata[`ALM_B_CLK_GONE] &&
       sclk_cnt_r < 16'h0010 && dclk_cnt_r < 16'h0010) |=> !stat_word[`ALM_B_CLK_GONE];
   endproperty
   a_clear_gone: assert property (p_clear_gone) else $error("clock gone not cleared");

   // Status reserved bits read zero
   property p_rsvd_stat;
      @(posedge ref_clk) disable iff (rst)
      (reg_rd && reg_addr == `ALM_OFS_STAT) |=> (reg_rdata[2:0] == 3'h0);
   endproperty
   a_rsvd_stat: assert property (p_rsvd_stat) else $error("status reserved not zero");

   // Failure bits written zero clear when no check is running
   property p_fail_clear;
      @(posedge ref_clk) disable iff (rst)
      (wr_fail && !check_valid) |=> ((fail_r & ~$past(reg_wdata[13:0])) == 14'h0000);
   endproperty
   a_fail_clear: assert property (p_fail_clear) else $error("failure bits not cleared");

   // Serializer passes samples through once clock gone is clear
   property p_mid_release;
      @(posedge ref_clk) disable iff (rst)
      !stat_word[`ALM_B_CLK_GONE] |=> (output_serializer_a == $past(sample_a) &&
                                       output_serializer_b == $past(sample_b));
   endproperty
   a_mid_release: assert property (p_mid_release) else $error("serializer stuck");

   // Pointer-empty bit written zero drops once the pointer is live again
   property p_zero_clear;
      @(posedge ref_clk) disable iff (rst)
      (wr_stat && !reg_wdata[`ALM_B_ZERO_A] && wr_ptr_a != 8'h00) |=> !stat_word[`ALM_B_ZERO_A];
   endproperty
   a_zero_clear: assert property (p_zero_clear) else $error("pointer-empty not cleared");

endmodule

// ===== alm_status_tb.sv
// Self-checking bench for the alarm status bank against a cycle model
`timescale 1ns/100ps

module tb
   import alm_pkg::*;
;
   logic      ref_clk, rst;
   alm_addr_t reg_addr;
   alm_word_t reg_wdata, reg_rdata, sample_a, sample_b, ser_a, ser_b;
   logic      reg_wr, reg_rd, check_valid, sample_clk_tick, data_clk_tick;
   logic      fa2, fa1, fac, fb2, fb1, fbc, ls, ld;
   logic [7:0] wr_ptr_a, wr_ptr_b;
   logic [1:0] interp_sel;
   alm_lane_t rx_a, rx_b, ex_a, ex_b;
   alm_word_t fail_m, stat_m, ena_m, rd_m, sa_m, sb_m, st, fs;
   integer    miscompares, comparisons, seed, cnt_s, cnt_d, i, k;
   logic      rnd_on, fifo_on;

   alm_status DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wr_ptr_a(wr_ptr_a),
      .wr_ptr_b(wr_ptr_b), .fifo_a_two_apart(fa2), .fifo_a_one_apart(fa1),
      .fifo_a_collision(fac), .fifo_b_two_apart(fb2), .fifo_b_one_apart(fb1),
      .fifo_b_collision(fbc), .sample_clk_tick(sample_clk_tick), .data_clk_tick(data_clk_tick),
      .interp_sel(interp_sel), .check_valid(check_valid), .rx_lane_a(rx_a), .rx_lane_b(rx_b),
      .exp_lane_a(ex_a), .exp_lane_b(ex_b), .sample_a(sample_a), .sample_b(sample_b),
      .output_serializer_a(ser_a), .output_serializer_b(ser_b));

   // 50 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task chk(input string n, input alm_word_t seen, input alm_word_t exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task test_done;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // One bus cycle; consecutive calls give back-to-back strobes
   task op(input logic w, input logic r, input alm_addr_t a, input alm_word_t d);
      @(posedge ref_clk);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
   endtask

   // Model sees inputs as they were before the edge, like the design
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fail_m = 16'h0000; stat_m = 16'h0000; ena_m = 16'h000E; rd_m = 16'h0000;
         sa_m = 16'h0000; sb_m = 16'h0000; cnt_s = 0; cnt_d = 0;
      end else begin
         rd_m = !reg_rd ? 16'h0000 : reg_addr == 8'h04 ? fail_m :
                reg_addr == 8'h05 ? stat_m : reg_addr == 8'h0A ? ena_m : 16'h0000;
         sa_m = stat_m[5] ? 16'h8000 : sample_a;
         sb_m = stat_m[5] ? 16'h8000 : sample_b;
         ls = cnt_s >= (16 << interp_sel);
         ld = cnt_d >= (16 << interp_sel);
         st = {wr_ptr_a == 8'h00, wr_ptr_b == 8'h00, fac & ena_m[1], fa1 & ena_m[2],
               fa2 & ena_m[3], fbc & ena_m[1], fb1 & ena_m[2], fb2 & ena_m[3], ls, ld, ls | ld,
               check_valid && rx_a != ex_a, check_valid && rx_b != ex_b, 3'h0};
         fs = check_valid ? {2'h0, rx_a ^ ex_a, rx_b ^ ex_b} : 16'h0000;
         if (reg_wr && reg_addr == 8'h04) fail_m = fail_m & reg_wdata;
         if (reg_wr && reg_addr == 8'h05) stat_m = stat_m & reg_wdata;
         if (reg_wr && reg_addr == 8'h0A) ena_m = reg_wdata & 16'h000E;
         stat_m = (stat_m | st) & 16'hFFF8;
         fail_m = (fail_m | fs) & 16'h3FFF;
         cnt_s = sample_clk_tick ? 0 : (cnt_s < 100000 ? cnt_s + 1 : cnt_s);
         cnt_d = data_clk_tick ? 0 : (cnt_d < 100000 ? cnt_d + 1 : cnt_d);
      end
   end

   // Compare away from the edge so every update has landed
   always @(negedge ref_clk) begin
      if (!rst) begin
         chk("reg_rdata", reg_rdata, rd_m);
         chk("ser_a", ser_a, sa_m);
         chk("ser_b", ser_b, sb_m);
      end
   end

   // Random data path stimulus; rare pointer zeros, frequent FIFO events
   always @(posedge ref_clk) begin
      if (rnd_on) begin
         sample_a <= 16'($random(seed));
         sample_b <= 16'($random(seed));
         rx_a <= 7'($random(seed));
         rx_b <= 7'($random(seed));
         ex_a <= 7'($random(seed));
         ex_b <= 7'($random(seed));
         check_valid <= ($random(seed) & 7) == 0;
         wr_ptr_a <= ($random(seed) & 31) == 0 ? 8'h00 : 8'h80;
         wr_ptr_b <= ($random(seed) & 31) == 0 ? 8'h00 : 8'h40;
         {fa2, fa1, fac, fb2, fb1, fbc} <= fifo_on ? 6'($random(seed) & $random(seed)) : 6'h00;
      end
   end

   // Watchdog sized well above the expected run
   initial begin
      #400000;
      miscompares++;
      test_done();
   end

   initial begin
      miscompares = 0; comparisons = 0; seed = 32'h51BEBCA4;
      rnd_on = 0; fifo_on = 0;
      rst = 1'b1; reg_addr = 8'h00; reg_wdata = 16'h0000; reg_wr = 1'b0; reg_rd = 1'b0;
      wr_ptr_a = 8'h01; wr_ptr_b = 8'h01; {fa2, fa1, fac, fb2, fb1, fbc} = 6'h00;
      sample_clk_tick = 1'b1; data_clk_tick = 1'b1; interp_sel = 2'h0; check_valid = 1'b0;
      rx_a = 7'h00; rx_b = 7'h00; ex_a = 7'h00; ex_b = 7'h00;
      sample_a = 16'h0000; sample_b = 16'h0000;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      // Reset values, enable register and an unmapped offset, back to back
      op(1'b0, 1'b1, 8'h04, 16'h0000);
      op(1'b0, 1'b1, 8'h05, 16'h0000);
      op(1'b0, 1'b1, 8'h0A, 16'h0000);
      op(1'b0, 1'b1, 8'h07, 16'h0000);
      op(1'b1, 1'b0, 8'h07, 16'hFFFF);
      op(1'b0, 1'b1, 8'h07, 16'h0000);
      rnd_on <= 1; fifo_on <= 1;
      // Random mixed traffic with write-to-clear races against new events
      for (i = 0; i < 300; i++) begin
         k = {$random(seed)} % 3;
         op(k == 1, k == 2, (i & 3) == 3 ? 8'h07 : (i & 1) ? 8'h05 : 8'h04, 16'($random(seed)));
      end
      // FIFO alarms with all three enables off, then restored
      op(1'b1, 1'b0, 8'h0A, 16'h0000);
      op(1'b1, 1'b0, 8'h05, 16'h0000);
      for (i = 0; i < 40; i++) op(1'b0, (i & 7) == 7, 8'h05, 16'h0000);
      op(1'b1, 1'b0, 8'h0A, 16'hFFFF);
      op(1'b0, 1'b1, 8'h0A, 16'h0000);
      fifo_on <= 0;
      // Clock loss at every interpolation setting; clear the whole status word first, and after each loss clear only the gone bit
      for (i = 0; i < 4; i++) begin
         op(1'b1, 1'b0, 8'h05, 16'h0000);
         op(1'b0, 1'b0, 8'h00, 16'h0000);
         interp_sel <= i[1:0];
         if (i[0]) data_clk_tick <= 1'b0;
         else sample_clk_tick <= 1'b0;
         repeat ((16 << i) + 6) @(posedge ref_clk);
         op(1'b0, 1'b1, 8'h05, 16'h0000);
         sample_clk_tick <= 1'b1;
         data_clk_tick <= 1'b1;
         op(1'b1, 1'b0, 8'h05, 16'hFFDF);
         op(1'b0, 1'b0, 8'h00, 16'h0000);
         @(posedge ref_clk);
         for (k = 0; k < 20; k++) op(1'b0, k == 5, 8'h05, 16'h0000);
      end
      // Mid-run reset with enables off; every register must return to its reset value
      op(1'b1, 1'b0, 8'h0A, 16'h0000);
      op(1'b0, 1'b1, 8'h0A, 16'h0000);
      op(1'b0, 1'b0, 8'h00, 16'h0000);
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      op(1'b0, 1'b1, 8'h0A, 16'h0000);
      op(1'b0, 1'b1, 8'h05, 16'h0000);
      op(1'b0, 1'b1, 8'h04, 16'h0000);
      op(1'b0, 1'b0, 8'h00, 16'h0000);
      repeat (4) @(posedge ref_clk);
      test_done();
   end
endmodule
